// File: rtl/ets_consts.svh
// Constants of the two-wire slave front end: field positions, counts and reset values
`ifndef ETS_CONSTS_SVH
`define ETS_CONSTS_SVH

// ****************************************************************
// Control byte layout
// ****************************************************************
`define ETS_CODE_MSB     7
`define ETS_CODE_LSB     4
`define ETS_CS_MSB       3
`define ETS_CS_LSB       1
`define ETS_RW_BIT       0
`define ETS_ADDR_HI_MSB  6

// ****************************************************************
// Bit framing
// ****************************************************************
`define ETS_LAST_DATA    4'h7
`define ETS_ACK_SLOT     4'h8
`define ETS_FIRST_BIT    4'h1
`define ETS_SYNC_STAGES  3

// ****************************************************************
// Reset values
// ****************************************************************
`define ETS_RST_ADDR     15'h0000
`define ETS_RST_BYTE     8'h00

`endif

// File: rtl/ets_pkg.sv
// Types shared by the two-wire slave front end
package ets_pkg;

    // Frame phase of the link side
    typedef enum logic [2:0] {
        PH_IDLE    = 3'b000,
        PH_CTRL    = 3'b001,
        PH_ADDR_HI = 3'b010,
        PH_ADDR_LO = 3'b011,
        PH_WDATA   = 3'b100,
        PH_RDATA   = 3'b101
    } ets_phase_e;

    // Written byte with its word address
    typedef struct packed {
        logic [14:0] addr;
        logic [7:0]  data;
    } ets_wr_s;

    // Link state sampled on rising serial clock
    typedef struct packed {
        ets_phase_e  phase;
        logic [3:0]  bit_cnt;
        logic [7:0]  shreg;
        logic [7:0]  tx;
        logic        ack_en;
        logic        rw;
        logic        start_seen;
        logic        busy_m;
        logic        busy_s;
        logic [14:0] addr;
        ets_wr_s     wr;
        logic        wr_tgl;
        logic        rd_tgl;
    } ets_lnk_s;

    // Data line driver updated on falling serial clock
    typedef struct packed {
        logic low;
    } ets_drv_s;

    // Core clock state
    typedef struct packed {
        logic    start_seen;
        logic    stop_seen;
        logic    wr_seen;
        logic    rd_seen;
        logic    got_data;
        logic    wr_stb;
        logic    write_go;
        logic    wp_block;
        logic    rd_adv;
        ets_wr_s wr;
    } ets_core_s;

endpackage

// File: rtl/ets_sync.sv
// Three-stage synchroniser that passes a bit once the last two stages agree
`timescale 1ns/100ps
`default_nettype none
`include "ets_consts.svh"

module ets_sync
    import ets_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         clk,   // Destination clock
    input  wire logic         rst,   // Async reset, high
    input  wire logic [W-1:0] d,     // Asynchronous inputs
    output logic      [W-1:0] q      // Agreed outputs
);

    typedef struct packed {
        logic [`ETS_SYNC_STAGES-1:0][W-1:0] st;
        logic [W-1:0]                       q;
    } ets_sync_s;

    ets_sync_s r;
    ets_sync_s next_r;

    // Shift chain; output follows only on agreement of stages two and three
    always_comb begin
        next_r       = r;
        next_r.st[0] = d;
        next_r.st[1] = r.st[0];
        next_r.st[2] = r.st[1];
        for (int i = 0; i < W; i++) begin
            if (r.st[1][i] == r.st[2][i]) begin
                next_r.q[i] = r.st[2][i];
            end
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign q = r.q;

endmodule
`default_nettype wire

// File: rtl/ets_front.sv
// Two-wire serial slave front end: framing, control byte decode, word address and write gating
//
// How it works
// - Selected only when all three chip-select bits equal the strap levels.
// - Data line is only pulled low or released, never driven high.
// - Data line changes only while serial clock is low, except Start/Stop.
// - Write-protect high blocks array writes; reads still work normally.
// - Data falling while clock high is a Start; decoding begins afresh.
// - Data rising while clock high is a Stop; it closes a write on the core side, the link phase is kept.
// - One bit per clock pulse, sampled during the clock high phase.
// - Each received byte is acknowledged on a ninth clock pulse.
// - No acknowledge at all while an internal write cycle runs.
// - Acknowledge holds the data line low for the whole clock high phase.
// - Master not acknowledging a read byte ends reading; line released.
// - Control byte: four-bit type code, three chip selects, then read/write.
// - Read/write bit one selects read, zero selects write.
// - Two address bytes follow a write byte, high first; top bit ignored.
// - Control byte acknowledged only on matching code and selects.
// - Write-protect sampled at the Stop of each write command.
`timescale 1ns/100ps
`default_nettype none
`include "ets_consts.svh"

module ets_front
    import ets_pkg::*;
#(
    parameter logic [3:0] DEV_CODE = 4'h5  // Device-type code, value arbitrary
) (
    input  wire logic        core_clk,               // Core clock, 40 MHz
    input  wire logic        sys_rst,                // Async reset, high
    input  wire logic        scl_clk,                // Serial clock from master
    input  wire logic        sda_in,                 // Data line level
    output logic             sda_out,                // Data line drive value
    output logic             sda_oe_n,               // Low while pulling line
    input  wire logic        chip_select_strap_high, // Select strap, top bit
    input  wire logic        chip_select_strap_mid,  // Select strap, middle bit
    input  wire logic        chip_select_strap_low,  // Select strap, low bit
    input  wire logic        wp_in,                  // Write-protect pin
    input  wire logic        busy_in,                // Internal write cycle running
    input  wire logic [7:0]  rd_data,                // Byte at addr_ptr
    output logic [14:0]      addr_ptr,               // Word address pointer
    output logic             wr_stb,                 // Byte received pulse
    output logic [7:0]       wr_data,                // Received byte
    output logic [14:0]      wr_addr,                // Address of received byte
    output logic             write_go,               // Start array write pulse
    output logic             wp_block,               // Write refused pulse
    output logic             rd_adv                  // Read byte consumed pulse
);

    // ****************************************************************
    // Decode helpers
    // ****************************************************************

    // Control byte matches type code and straps
    function automatic logic ctrl_match(input logic [7:0] b, input logic [2:0] cs);
        ctrl_match = (b[`ETS_CODE_MSB:`ETS_CODE_LSB] == DEV_CODE) &&
                     (b[`ETS_CS_MSB:`ETS_CS_LSB] == cs);
    endfunction

    // Bit of the transmit byte for a slot, MSB first
    function automatic logic tx_bit(input logic [7:0] b, input logic [3:0] n);
        tx_bit = b[3'(`ETS_LAST_DATA - n)];
    endfunction

    logic [2:0] cs_straps;
    logic       start_tgl;
    logic       stop_tgl;
    logic       start_pend;
    logic [7:0] byte_in;
    ets_lnk_s   lnk;
    ets_lnk_s   next_lnk;
    ets_drv_s   drv;
    ets_drv_s   next_drv;
    ets_core_s  core;
    ets_core_s  next_core;
    logic [4:0] sync_q;
    logic       start_s;
    logic       stop_s;
    logic       wr_s;
    logic       rd_s;
    logic       wp_s;
    logic       busy_q;

    // Straps held static by the board
    assign cs_straps = {chip_select_strap_high, chip_select_strap_mid, chip_select_strap_low};

    // ****************************************************************
    // Start and Stop detection on data edges
    // ****************************************************************

    // Falling data with clock high toggles the start marker
    always_ff @(negedge sda_in or posedge sys_rst) begin
        if (sys_rst) begin
            start_tgl <= 1'b0;
        end else if (scl_clk) begin
            start_tgl <= ~start_tgl;
        end
    end

    // Rising data with clock high toggles the stop marker
    always_ff @(posedge sda_in or posedge sys_rst) begin
        if (sys_rst) begin
            stop_tgl <= 1'b0;
        end else if (scl_clk) begin
            stop_tgl <= ~stop_tgl;
        end
    end

    assign start_pend = (start_tgl != lnk.start_seen);

    // Write-cycle flag crosses into the serial clock domain
    ets_sync #(
        .W (1)
    ) u_busy_sync (
        .clk (scl_clk),
        .rst (sys_rst),
        .d   (busy_in),
        .q   (busy_q)
    );

    // ****************************************************************
    // Link side, rising serial clock
    // ****************************************************************

    // Bit shift, byte framing and control decode
    always_comb begin
        next_lnk        = lnk;
        byte_in         = {lnk.shreg[6:0], sda_in};
        next_lnk.busy_m = busy_q;
        next_lnk.busy_s = lnk.busy_m;
        if (start_pend) begin
            next_lnk.start_seen = start_tgl;
            next_lnk.phase      = PH_CTRL;
            next_lnk.shreg      = byte_in;
            next_lnk.bit_cnt    = `ETS_FIRST_BIT;
            next_lnk.ack_en     = 1'b0;
        end else if (lnk.phase != PH_IDLE) begin
            if (lnk.bit_cnt != `ETS_ACK_SLOT) begin
                next_lnk.shreg   = byte_in;
                next_lnk.bit_cnt = lnk.bit_cnt + 4'h1;
                if (lnk.bit_cnt == `ETS_LAST_DATA) begin
                    if (lnk.phase == PH_CTRL) begin
                        next_lnk.ack_en = ctrl_match(byte_in, cs_straps) && !lnk.busy_s;
                    end else begin
                        next_lnk.ack_en = (lnk.phase != PH_RDATA) && !lnk.busy_s;
                    end
                end
            end else begin
                next_lnk.bit_cnt = 4'h0;
                next_lnk.ack_en  = 1'b0;
                unique case (lnk.phase)
                    PH_CTRL: begin
                        if (ctrl_match(lnk.shreg, cs_straps) && !lnk.busy_s) begin
                            next_lnk.rw = lnk.shreg[`ETS_RW_BIT];
                            if (lnk.shreg[`ETS_RW_BIT]) begin
                                next_lnk.phase = PH_RDATA;
                                next_lnk.tx    = rd_data;
                                next_lnk.addr  = lnk.addr + 15'h0001;
                                next_lnk.rd_tgl = ~lnk.rd_tgl;
                            end else begin
                                next_lnk.phase = PH_ADDR_HI;
                            end
                        end else begin
                            next_lnk.phase = PH_IDLE;
                        end
                    end
                    PH_ADDR_HI: begin
                        next_lnk.addr[14:8] = lnk.shreg[`ETS_ADDR_HI_MSB:0];
                        next_lnk.phase      = PH_ADDR_LO;
                    end
                    PH_ADDR_LO: begin
                        next_lnk.addr[7:0] = lnk.shreg;
                        next_lnk.phase     = PH_WDATA;
                    end
                    PH_WDATA: begin
                        next_lnk.wr.data = lnk.shreg;
                        next_lnk.wr.addr = lnk.addr;
                        next_lnk.wr_tgl  = ~lnk.wr_tgl;
                        next_lnk.addr    = lnk.addr + 15'h0001;
                    end
                    PH_RDATA: begin
                        if (sda_in) begin
                            next_lnk.phase = PH_IDLE;
                        end else begin
                            next_lnk.tx     = rd_data;
                            next_lnk.addr   = lnk.addr + 15'h0001;
                            next_lnk.rd_tgl = ~lnk.rd_tgl;
                        end
                    end
                    default: begin
                        next_lnk.phase = PH_IDLE;
                    end
                endcase
            end
        end
    end

    // Link state register
    always_ff @(posedge scl_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lnk <= '{phase: PH_IDLE, bit_cnt: 4'h0, shreg: `ETS_RST_BYTE, tx: `ETS_RST_BYTE,
                     ack_en: 1'b0, rw: 1'b0, start_seen: 1'b0, busy_m: 1'b0, busy_s: 1'b0,
                     addr: `ETS_RST_ADDR, wr: '{addr: `ETS_RST_ADDR, data: `ETS_RST_BYTE},
                     wr_tgl: 1'b0, rd_tgl: 1'b0};
        end else begin
            lnk <= next_lnk;
        end
    end

    // ****************************************************************
    // Data line driver, falling serial clock
    // ****************************************************************

    // Acknowledge or read bit set up while clock is low
    always_comb begin
        next_drv.low = 1'b0;
        if (!start_pend && (lnk.phase != PH_IDLE)) begin
            if ((lnk.bit_cnt == `ETS_ACK_SLOT) && (lnk.phase != PH_RDATA)) begin
                next_drv.low = lnk.ack_en;
            end else if ((lnk.phase == PH_RDATA) && (lnk.bit_cnt != `ETS_ACK_SLOT)) begin
                next_drv.low = !tx_bit(lnk.tx, lnk.bit_cnt);
            end
        end
    end

    // Driver register, changes only on falling clock
    always_ff @(negedge scl_clk or posedge sys_rst) begin
        if (sys_rst) begin
            drv <= '{low: 1'b0};
        end else begin
            drv <= next_drv;
        end
    end

    // Open drain: pull low or release
    assign sda_out  = 1'b0;
    assign sda_oe_n = !drv.low;
    assign addr_ptr = lnk.addr;

    // ****************************************************************
    // Core side
    // ****************************************************************

    ets_sync #(
        .W (5)
    ) u_sync (
        .clk (core_clk),
        .rst (sys_rst),
        .d   ({start_tgl, stop_tgl, lnk.wr_tgl, lnk.rd_tgl, wp_in}),
        .q   (sync_q)
    );

    assign {start_s, stop_s, wr_s, rd_s, wp_s} = sync_q;

    // Event decode, write gating at Stop
    always_comb begin
        next_core            = core;
        next_core.start_seen = start_s;
        next_core.stop_seen  = stop_s;
        next_core.wr_seen    = wr_s;
        next_core.rd_seen    = rd_s;
        next_core.wr_stb     = (wr_s != core.wr_seen);
        next_core.rd_adv     = (rd_s != core.rd_seen);
        next_core.write_go   = 1'b0;
        next_core.wp_block   = 1'b0;
        if (start_s != core.start_seen) begin
            next_core.got_data = 1'b0;
        end
        if (wr_s != core.wr_seen) begin
            next_core.wr       = lnk.wr;
            next_core.got_data = 1'b1;
        end
        if (stop_s != core.stop_seen) begin
            next_core.got_data = 1'b0;
            if (core.got_data || (wr_s != core.wr_seen)) begin
                next_core.write_go = !wp_s;
                next_core.wp_block = wp_s;
            end
        end
    end

    // Core state register
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            core <= '0;
        end else begin
            core <= next_core;
        end
    end

    assign wr_stb   = core.wr_stb;
    assign wr_data  = core.wr.data;
    assign wr_addr  = core.wr.addr;
    assign write_go = core.write_go;
    assign wp_block = core.wp_block;
    assign rd_adv   = core.rd_adv;

    // ****************************************************************
    // Assertions
    // ****************************************************************

    busy_noack_a: assert property (@(posedge scl_clk) disable iff (sys_rst)
        (!start_pend && lnk.phase != PH_IDLE && lnk.bit_cnt == 4'h7 && lnk.busy_s) |=> !lnk.ack_en)
        else $error("acknowledge armed during write cycle");

    ctrl_accept_a: assert property (@(posedge scl_clk) disable iff (sys_rst)
        (!start_pend && lnk.phase == PH_CTRL && lnk.bit_cnt == 4'h8 && lnk.ack_en)
        |=> (lnk.phase == PH_ADDR_HI || lnk.phase == PH_RDATA))
        else $error("accepted control byte did not advance");

    ctrl_reject_a: assert property (@(posedge scl_clk) disable iff (sys_rst)
        (!start_pend && lnk.phase == PH_CTRL && lnk.bit_cnt == 4'h8 && !ctrl_match(lnk.shreg, cs_straps))
        |=> lnk.phase == PH_IDLE ##1 (lnk.phase == PH_IDLE || start_pend))
        else $error("mismatched control byte not ignored");

    rw_select_a: assert property (@(posedge scl_clk) disable iff (sys_rst)
        (!start_pend && lnk.phase == PH_CTRL && lnk.bit_cnt == 4'h8 && lnk.ack_en)
        |=> ((lnk.phase == PH_RDATA) == $past(lnk.shreg[0])))
        else $error("read/write bit decoded wrongly");

    start_restart_a: assert property (@(posedge scl_clk) disable iff (sys_rst)
        start_pend |=> (lnk.phase == PH_CTRL && lnk.bit_cnt == 4'h1 && lnk.addr == $past(lnk.addr)))
        else $error("start did not restart control decode");

    addr_low_a: assert property (@(posedge scl_clk) disable iff (sys_rst)
        (!start_pend && lnk.phase == PH_ADDR_LO && lnk.bit_cnt == 4'h8)
        |=> (lnk.addr[7:0] == $past(lnk.shreg) && lnk.phase == PH_WDATA))
        else $error("low address byte not loaded");

    read_nack_a: assert property (@(posedge scl_clk) disable iff (sys_rst)
        (!start_pend && lnk.phase == PH_RDATA && lnk.bit_cnt == 4'h8 && sda_in) |=> lnk.phase == PH_IDLE)
        else $error("read not ended by missing acknowledge");

    ack_low_a: assert property (@(posedge scl_clk) disable iff (sys_rst)
        (lnk.bit_cnt == 4'h8 && lnk.phase != PH_RDATA && !sda_oe_n) |-> !sda_in)
        else $error("line not low in acknowledge slot");

    drive_idle_a: assert property (@(posedge scl_clk) disable iff (sys_rst)
        !sda_oe_n |-> ($past(lnk.phase) != PH_IDLE && sda_out == 1'b0))
        else $error("line pulled while idle");

    wp_gate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        write_go |-> (!$past(wp_s) && !wp_block))
        else $error("write started while protected");

    write_cov: cover property (@(posedge core_clk) disable iff (sys_rst) write_go);
    block_cov: cover property (@(posedge core_clk) disable iff (sys_rst) wp_block);
    read_cov:  cover property (@(posedge scl_clk) disable iff (sys_rst)
        lnk.phase == PH_RDATA ##1 lnk.phase == PH_IDLE);

endmodule
`default_nettype wire

// File: bench/ets_master.sv
// Behavioural bus master that drives the serial clock and data line
`timescale 1ns/100ps
`default_nettype none

module ets_master (
    output logic      scl,     // Serial clock
    output logic      sda_m,   // Master data drive, 1 = released
    input  wire logic sda_bus  // Resolved data line
);
    // Bus idle with both lines high before any transfer
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end

    // One bit per pulse, data changed only while clock is low
    task automatic bit_out(input logic b);
        sda_m = b;
        #20 scl = 1'b1;
        #40 scl = 1'b0;
        #20;
    endtask

    // Released line sampled mid high phase
    task automatic bit_in(output logic r);
        sda_m = 1'b1;
        #20 scl = 1'b1;
        #20 r = sda_bus;
        #20 scl = 1'b0;
        #20;
    endtask

    // Start or repeated Start, data falls with clock high
    task automatic start();
        sda_m = 1'b1;
        #20 scl = 1'b1;
        #40 sda_m = 1'b0;
        #40 scl = 1'b0;
        #20;
    endtask

    // Stop, data rises with clock high; clock then stands still
    task automatic stop();
        sda_m = 1'b0;
        #20 scl = 1'b1;
        #40 sda_m = 1'b1;
        #40;
    endtask

    // Byte out MSB first, ninth pulse for the acknowledge
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_out(d[i]);
        bit_in(r);
        ack = ~r;
    endtask

    // Byte in; low on the ninth pulse asks for more, high ends it
    task automatic rd_byte(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) bit_in(d[i]);
        bit_out(last);
    endtask
endmodule

`default_nettype wire

// File: bench/ets_front_tb.sv
// Self-checking bench of the two-wire slave front end
`timescale 1ns/100ps
`default_nettype none

module ets_front_tb;
    logic        core_clk = 1'b0;
    logic        sys_rst  = 1'b0;
    logic        wp_in    = 1'b0;
    logic        busy_in  = 1'b0;
    wire         scl, sda_m, sda_out, sda_oe_n, sda_bus;
    logic [14:0] addr_ptr, wr_addr;
    logic [7:0]  wr_data, d;
    logic [7:0]  rd_data;
    logic        wr_stb, write_go, wp_block, rd_adv, ack;
    int          errors, comparisons, n_go, n_blk, n_stb, n_adv;
    logic [7:0]  ctrl_row [6] = '{8'h6A, 8'h6B, 8'h7A, 8'h62, 8'h6E, 8'h68};
    logic        ack_row  [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

    // Wired-AND with pull-up
    assign sda_bus = (sda_oe_n ? 1'b1 : sda_out) & sda_m;
    // Memory model: each byte derived from its own address
    assign rd_data = addr_ptr[7:0] ^ 8'h96;
    always #12.5 core_clk = ~core_clk;

    // Pulse counters
    always @(posedge core_clk) begin
        if (write_go) n_go++;
        if (wp_block) n_blk++;
        if (wr_stb) n_stb++;
        if (rd_adv) n_adv++;
    end

    ets_master m (.scl(scl), .sda_m(sda_m), .sda_bus(sda_bus));

    ets_front #(.DEV_CODE(4'h6)) dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .scl_clk(scl), .sda_in(sda_bus),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .chip_select_strap_high(1'b1),
        .chip_select_strap_mid(1'b0), .chip_select_strap_low(1'b1), .wp_in(wp_in),
        .busy_in(busy_in), .rd_data(rd_data), .addr_ptr(addr_ptr), .wr_stb(wr_stb),
        .wr_data(wr_data), .wr_addr(wr_addr), .write_go(write_go),
        .wp_block(wp_block), .rd_adv(rd_adv));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask

    // Full write: control, address 0x7F34 with top bit set, one data byte
    task automatic wframe(input logic [7:0] dat);
        m.start();
        m.wr_byte(8'h6A, ack);
        m.wr_byte(8'hFF, ack);
        m.wr_byte(8'h34, ack);
        m.wr_byte(dat, ack);
        check("data ack", ack, 1'b1);
        m.stop();
        idle(10);
    endtask

    // Watchdog
    initial begin
        #300000;
        errors++;
        close_out();
    end

    initial begin
        // Raised after time zero so every asynchronous reset sees the edge
        #2 sys_rst = 1'b1;
        idle(10);
        check("oe_n in reset", sda_oe_n, 1'b1);
        check("ptr in reset", addr_ptr, 15'h0000);
        sys_rst = 1'b0;
        idle(4);
        // Control byte table: match, read, wrong code, each strap wrong
        for (int i = 0; i < 6; i++) begin
            m.start();
            m.wr_byte(ctrl_row[i], ack);
            check("ctrl ack", ack, ack_row[i]);
            if (ctrl_row[i][0] && ack) begin
                m.rd_byte(1'b1, d);
                check("read byte", d, 8'h96);
            end else begin
                m.wr_byte(8'h00, ack);
                check("next ack", ack, ack_row[i]);
            end
            m.stop();
            idle(10);
        end
        check("no go", n_go, 15'h0000);
        $display("control table done");
        wframe(8'h5A);
        check("wr addr", wr_addr, 15'h7F34);
        check("wr data", wr_data, 8'h5A);
        check("go", n_go, 15'h0001);
        check("ptr", addr_ptr, 15'h7F35);
        wp_in = 1'b1;
        idle(4);
        wframe(8'h11);
        check("go wp", n_go, 15'h0001);
        check("block", n_blk, 15'h0001);
        check("stb", n_stb, 15'h0002);
        wp_in = 1'b0;
        $display("write test done");
        busy_in = 1'b1;
        idle(4);
        m.start();
        m.wr_byte(8'h6A, ack);
        check("busy ack", ack, 1'b0);
        m.stop();
        busy_in = 1'b0;
        idle(10);
        $display("busy test done");
        // Address, repeated Start, two-byte read
        m.start();
        m.wr_byte(8'h6A, ack);
        m.wr_byte(8'h81, ack);
        m.wr_byte(8'h22, ack);
        m.start();
        m.wr_byte(8'h6B, ack);
        check("rs ack", ack, 1'b1);
        m.rd_byte(1'b0, d);
        check("seq 0", d, 8'hB4);
        m.rd_byte(1'b1, d);
        check("seq 1", d, 8'hB5);
        check("released", sda_oe_n, 1'b1);
        m.stop();
        idle(10);
        check("rs ptr", addr_ptr, 15'h0124);
        check("adv", n_adv, 15'h0003);
        check("go rs", n_go, 15'h0001);
        check("drive low", sda_out, 1'b0);
        $display("repeated start test done");
        // Reset in mid-run, then a write must still land
        sys_rst = 1'b1;
        idle(2);
        check("ptr mid reset", addr_ptr, 15'h0000);
        check("oe_n mid reset", sda_oe_n, 1'b1);
        sys_rst = 1'b0;
        idle(4);
        wframe(8'h3C);
        check("wr data after reset", wr_data, 8'h3C);
        check("wr addr after reset", wr_addr, 15'h7F34);
        check("go after reset", n_go, 15'h0002);
        check("stb after reset", n_stb, 15'h0003);
        $display("mid-run reset test done");
        close_out();
    end
endmodule

`default_nettype wire
